//--- core/ipc_regs.svh
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH
// Byte addresses of the register words
`define IPC_ADDR_CARRIER 8'h00
`define IPC_ADDR_POINTS 8'h04
`define IPC_ADDR_MODUL 8'h08
`define IPC_ADDR_MISC 8'h0C
`define IPC_ADDR_THERM 8'h10
`define IPC_ADDR_BUSNOM 8'h14
`define IPC_ADDR_STATUS 8'h18
// Field positions
`define IPC_CAR_SET_LSB 0
`define IPC_CAR_LOW_LSB 8
`define IPC_CAR_HIGH_LSB 16
`define IPC_CAR_ADJ_LSB 24
`define IPC_PT_ONE_LSB 0
`define IPC_PT_TWO_LSB 16
`define IPC_MOD_SCHEME_LSB 0
`define IPC_MOD_DISC_LSB 8
`define IPC_MOD_LIMIT_LSB 16
`define IPC_MISC_AVR_LSB 0
`define IPC_MISC_BRAKE_LSB 4
`define IPC_MISC_SWAP_LSB 8
`define IPC_MISC_FAN_LSB 12
`define IPC_MISC_DUTY_LSB 16
`define IPC_TH_FAN_LSB 0
`define IPC_TH_DERATE_LSB 8
// Reset values
`define IPC_RST_ADJUST 2'h0
`define IPC_RST_PT_ONE 16'h02BC
`define IPC_RST_PT_TWO 16'h1388
`define IPC_RST_SCHEME 2'h0
`define IPC_RST_DISC 7'h1E
`define IPC_RST_LIMIT 7'h69
`define IPC_RST_AVR 1'h1
`define IPC_RST_BRAKE 2'h1
`define IPC_RST_SWAP 1'h0
`define IPC_RST_FAN 2'h0
`define IPC_RST_DUTY 1'h0
`define IPC_RST_FAN_TEMP 8'h3C
`define IPC_RST_DERATE_TEMP 8'h50
`define IPC_RST_BUSNOM 16'h021C
`define IPC_RST_LFSR 16'hACE1
// Ranges and timing
`define IPC_CARRIER_MIN 8'h0A
`define IPC_CARRIER_MAX 8'h96
`define IPC_DISC_MIN 7'h0A
`define IPC_DISC_MAX 7'h64
`define IPC_LIMIT_MIN 7'h32
`define IPC_LIMIT_MAX 7'h6E
`define IPC_LIMIT_FULL 7'h64
`define IPC_Q15_FULL 32767
`define IPC_GAIN_ONE 14'h1000
`define IPC_GAIN_MAX 14'h1FFF
`define IPC_CLK_HZ 250000000
`define IPC_CARRIER_UNIT_HZ 100
`define IPC_HALF_NUM (`IPC_CLK_HZ / (2 * `IPC_CARRIER_UNIT_HZ))
`endif

//--- core/ipc_pkg.sv
package ipc_pkg;
  typedef logic [15:0] ipc_freq_t;
  typedef logic signed [15:0] ipc_ref_t;
  typedef logic [7:0] ipc_khz_t;
  typedef logic [17:0] ipc_cnt_t;
  typedef enum logic [1:0] {
    IPC_SCHEME_SV,
    IPC_SCHEME_SV_DPWM,
    IPC_SCHEME_RANDOM
  } ipc_scheme_e;

  // Divide by zero saturates instead of giving x
  function automatic logic [31:0] ipc_div(input logic [31:0] n, input logic [31:0] d);
    logic [31:0] r;
    r = 32'hFFFFFFFF;
    if (d != 32'h00000000) begin
      r = n / d;
    end
    return r;
  endfunction
endpackage

//--- core/ipc_car_if.sv
`timescale 1ns/1ps
interface ipc_car_if;
  import ipc_pkg::*;
  ipc_khz_t base_khz;
  ipc_khz_t low_khz;
  ipc_khz_t high_khz;
  logic adj_speed;
  logic adj_temp;
  ipc_freq_t pt_one;
  ipc_freq_t pt_two;
  ipc_freq_t out_freq;
  logic [7:0] drive_temp;
  logic [7:0] derate_temp;
  logic random_en;
  ipc_cnt_t cnt;
  ipc_cnt_t half_next;
  logic period_end;
  logic count_up;
  ipc_khz_t khz;
  modport ctrl (output base_khz, low_khz, high_khz, adj_speed, adj_temp, pt_one, pt_two,
    out_freq, drive_temp, derate_temp, random_en,
    input cnt, half_next, period_end, count_up, khz);
  modport gen (input base_khz, low_khz, high_khz, adj_speed, adj_temp, pt_one, pt_two,
    out_freq, drive_temp, derate_temp, random_en,
    output cnt, half_next, period_end, count_up, khz);
endinterface

//--- core/ipc_carrier.sv
`timescale 1ns/1ps
`include "ipc_regs.svh"
module ipc_carrier (
  input wire logic sys_clk,
  input wire logic rst,
  ipc_car_if.gen car
);
  import ipc_pkg::*;
  ipc_cnt_t cnt_q, cnt_d, half_q, half_d, nominal, eighth;
  logic up_q, up_d;
  ipc_khz_t khz_q, khz_d, target, dk;
  logic [15:0] lfsr_q, lfsr_d, dfreq, dspan;
  logic [31:0] frac;
  logic [21:0] jit;
  logic ends;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    target = car.base_khz;
    dfreq = car.out_freq - car.pt_one;
    dspan = car.pt_two - car.pt_one;
    dk = (car.high_khz >= car.low_khz) ? car.high_khz - car.low_khz : car.low_khz - car.high_khz;
    frac = ipc_div({16'h0000, dfreq} * {24'h000000, dk}, {16'h0000, dspan});
    if (car.adj_speed) begin
      if (car.out_freq < car.pt_one) begin
        target = car.low_khz;
      end else if (car.out_freq > car.pt_two) begin
        target = car.high_khz;
      end else if (dspan == 16'h0000) begin
        target = car.high_khz;
      end else if (car.high_khz >= car.low_khz) begin
        target = car.low_khz + frac[7:0];
      end else begin
        target = car.low_khz - frac[7:0];
      end
    end
    // Hot drive halves the carrier to cut switching loss
    if (car.adj_temp && car.drive_temp > car.derate_temp) begin
      target = ((target >> 1) < `IPC_CARRIER_MIN) ? `IPC_CARRIER_MIN : target >> 1;
    end
    nominal = ipc_cnt_t'(ipc_div(32'(`IPC_HALF_NUM), {24'h000000, target}));
    eighth = nominal >> 3;
    jit = ({4'h0, eighth} * {18'h00000, lfsr_q[3:0]}) >> 3;
    ends = !up_q && cnt_q <= 18'h00001;
    cnt_d = cnt_q;
    up_d = up_q;
    half_d = half_q;
    khz_d = khz_q;
    lfsr_d = lfsr_q;
    if (up_q) begin
      if (cnt_q + 18'h00001 >= half_q) begin
        cnt_d = half_q;
        up_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 18'h00001;
      end
    end else if (ends) begin
      // Period length only changes at the valley, so no pulse is cut
      cnt_d = 18'h00000;
      up_d = 1'b1;
      khz_d = target;
      lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      half_d = car.random_en ? nominal - eighth + jit[17:0] : nominal;
    end else begin
      cnt_d = cnt_q - 18'h00001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 18'h00000;
      up_q <= 1'b1;
      half_q <= 18'h07A12;
      khz_q <= 8'h28;
      lfsr_q <= `IPC_RST_LFSR;
    end else begin
      cnt_q <= cnt_d;
      up_q <= up_d;
      half_q <= half_d;
      khz_q <= khz_d;
      lfsr_q <= lfsr_d;
    end
  end

  assign car.cnt = cnt_q;
  assign car.half_next = half_d;
  assign car.period_end = ends;
  assign car.count_up = up_q;
  assign car.khz = khz_q;
endmodule

//--- core/ipc_top.sv
`timescale 1ns/1ps
`include "ipc_regs.svh"
module ipc_top #(
  parameter logic [7:0] CARRIER_DEFAULT = 8'h28
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ipc_pkg::ipc_freq_t out_freq,
  input wire ipc_pkg::ipc_ref_t ref_u,
  input wire ipc_pkg::ipc_ref_t ref_v,
  input wire ipc_pkg::ipc_ref_t ref_w,
  input wire logic [7:0] mod_pct,
  input wire logic [15:0] dc_bus_volt,
  input wire logic [7:0] drive_temp,
  input wire logic drive_running,
  input wire logic ramp_stop,
  output logic pwm_u,
  output logic pwm_v,
  output logic pwm_w,
  output logic brake_chopper_en,
  output logic fan_on,
  output logic light_duty
);
  import ipc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [6:0] clamp7(input logic [6:0] v, input logic [6:0] lo,
                                        input logic [6:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [19:0] scale(input ipc_ref_t r, input logic [13:0] g);
    logic signed [30:0] p;
    p = r * $signed({1'b0, g});
    return {p[30], p[30:12]};
  endfunction

  function automatic logic signed [20:0] clip(input logic signed [20:0] v,
                                              input logic signed [20:0] lim);
    return (v > lim) ? lim : ((v < -lim) ? -lim : v);
  endfunction

  function automatic ipc_cnt_t thresh(input logic signed [20:0] v, input ipc_cnt_t half);
    logic signed [21:0] off;
    logic [35:0] prod;
    off = {v[20], v} + 22'sh008000;
    if (off < 0) begin
      off = 22'sh000000;
    end
    prod = {18'h00000, off[17:0]} * {18'h00000, half};
    return prod[33:16];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  ipc_khz_t carrier_freq_setting_q, carrier_freq_setting_d;
  ipc_khz_t low_speed_carrier_q, low_speed_carrier_d;
  ipc_khz_t high_speed_carrier_q, high_speed_carrier_d;
  logic [1:0] carrier_adjust_select_q, carrier_adjust_select_d;
  ipc_freq_t carrier_switch_point_one_q, carrier_switch_point_one_d;
  ipc_freq_t carrier_switch_point_two_q, carrier_switch_point_two_d;
  ipc_scheme_e modulation_scheme_select_q, modulation_scheme_select_d;
  logic [6:0] discontinuous_switch_point_q, discontinuous_switch_point_d;
  logic [6:0] modulation_limit_q, modulation_limit_d;
  logic bus_voltage_compensation_enable_q, bus_voltage_compensation_enable_d;
  logic [1:0] brake_chopper_mode_q, brake_chopper_mode_d;
  logic phase_swap_select_q, phase_swap_select_d;
  logic [1:0] fan_control_mode_q, fan_control_mode_d;
  logic duty_type_select_q, duty_type_select_d;
  logic [7:0] fan_temp_q, fan_temp_d, derate_temp_q, derate_temp_d;
  logic [15:0] bus_nominal_q, bus_nominal_d;
  logic [31:0] prdata_q, prdata_d, rd_word, wr_word, mask;
  logic pready_q, pready_d, pslverr_q, pslverr_d, mapped, wr_en;

  // Datapath state
  ipc_cnt_t thr_u_q, thr_u_d, thr_v_q, thr_v_d, thr_w_q, thr_w_d;
  logic pwm_u_q, pwm_u_d, pwm_v_q, pwm_v_d, pwm_w_q, pwm_w_d;
  logic brake_q, brake_d, fan_q, fan_d, light_q, light_d;
  logic dpwm_q, dpwm_d, overmod_q, overmod_d;
  logic [13:0] gain;
  logic [31:0] gain_raw, lim_raw;
  logic signed [20:0] lim, s_u, s_v, s_w, mx, mn, sum, cm, p_u, p_v, p_w;
  logic dpwm_now;

  ipc_car_if car ();

  ipc_carrier u_carrier (
    .sys_clk(sys_clk),
    .rst(rst),
    .car(car)
  );

  assign car.base_khz = carrier_freq_setting_q;
  assign car.low_khz = low_speed_carrier_q;
  assign car.high_khz = high_speed_carrier_q;
  assign car.adj_speed = carrier_adjust_select_q[0];
  assign car.adj_temp = carrier_adjust_select_q[1];
  assign car.pt_one = carrier_switch_point_one_q;
  assign car.pt_two = carrier_switch_point_two_q;
  assign car.out_freq = out_freq;
  assign car.drive_temp = drive_temp;
  assign car.derate_temp = derate_temp_q;
  assign car.random_en = modulation_scheme_select_q == IPC_SCHEME_RANDOM;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, no wait state: pready rises in the first access cycle
  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h00000000;
    unique case (paddr)
      `IPC_ADDR_CARRIER: rd_word = {6'h00, carrier_adjust_select_q, high_speed_carrier_q,
                                    low_speed_carrier_q, carrier_freq_setting_q};
      `IPC_ADDR_POINTS: rd_word = {carrier_switch_point_two_q, carrier_switch_point_one_q};
      `IPC_ADDR_MODUL: rd_word = {9'h000, modulation_limit_q, 1'b0,
                                  discontinuous_switch_point_q, 6'h00,
                                  modulation_scheme_select_q};
      `IPC_ADDR_MISC: rd_word = {15'h0000, duty_type_select_q, 2'h0, fan_control_mode_q,
                                 3'h0, phase_swap_select_q, 2'h0, brake_chopper_mode_q,
                                 3'h0, bus_voltage_compensation_enable_q};
      `IPC_ADDR_THERM: rd_word = {16'h0000, derate_temp_q, fan_temp_q};
      `IPC_ADDR_BUSNOM: rd_word = {16'h0000, bus_nominal_q};
      `IPC_ADDR_STATUS: rd_word = {19'h00000, car.count_up, brake_q, fan_q, overmod_q,
                                   dpwm_q, car.khz};
      default: mapped = 1'b0;
    endcase
    mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wr_word = (rd_word & ~mask) | (pwdata & mask);
    wr_en = psel && penable && pready_q && pwrite && mapped;
    pready_d = psel && !penable;
    pslverr_d = pslverr_q;
    prdata_d = prdata_q;
    if (psel && !penable) begin
      pslverr_d = !mapped;
      prdata_d = pwrite ? 32'h00000000 : rd_word;
    end
    carrier_freq_setting_d = carrier_freq_setting_q;
    low_speed_carrier_d = low_speed_carrier_q;
    high_speed_carrier_d = high_speed_carrier_q;
    carrier_adjust_select_d = carrier_adjust_select_q;
    carrier_switch_point_one_d = carrier_switch_point_one_q;
    carrier_switch_point_two_d = carrier_switch_point_two_q;
    modulation_scheme_select_d = modulation_scheme_select_q;
    discontinuous_switch_point_d = discontinuous_switch_point_q;
    modulation_limit_d = modulation_limit_q;
    bus_voltage_compensation_enable_d = bus_voltage_compensation_enable_q;
    brake_chopper_mode_d = brake_chopper_mode_q;
    phase_swap_select_d = phase_swap_select_q;
    fan_control_mode_d = fan_control_mode_q;
    duty_type_select_d = duty_type_select_q;
    fan_temp_d = fan_temp_q;
    derate_temp_d = derate_temp_q;
    bus_nominal_d = bus_nominal_q;
    if (wr_en) begin
      unique case (paddr)
        `IPC_ADDR_CARRIER: begin
          carrier_freq_setting_d = clamp8(wr_word[`IPC_CAR_SET_LSB +: 8],
                                          `IPC_CARRIER_MIN, `IPC_CARRIER_MAX);
          low_speed_carrier_d = clamp8(wr_word[`IPC_CAR_LOW_LSB +: 8],
                                       `IPC_CARRIER_MIN, `IPC_CARRIER_MAX);
          high_speed_carrier_d = clamp8(wr_word[`IPC_CAR_HIGH_LSB +: 8],
                                        `IPC_CARRIER_MIN, `IPC_CARRIER_MAX);
          carrier_adjust_select_d = wr_word[`IPC_CAR_ADJ_LSB +: 2];
        end
        `IPC_ADDR_POINTS: begin
          carrier_switch_point_one_d = wr_word[`IPC_PT_ONE_LSB +: 16];
          carrier_switch_point_two_d = wr_word[`IPC_PT_TWO_LSB +: 16];
        end
        `IPC_ADDR_MODUL: begin
          // Unused code 3 falls back to plain space vector
          modulation_scheme_select_d = (wr_word[`IPC_MOD_SCHEME_LSB +: 2] == 2'h3) ?
              IPC_SCHEME_SV : ipc_scheme_e'(wr_word[`IPC_MOD_SCHEME_LSB +: 2]);
          discontinuous_switch_point_d = clamp7(wr_word[`IPC_MOD_DISC_LSB +: 7],
                                                `IPC_DISC_MIN, `IPC_DISC_MAX);
          modulation_limit_d = clamp7(wr_word[`IPC_MOD_LIMIT_LSB +: 7],
                                      `IPC_LIMIT_MIN, `IPC_LIMIT_MAX);
        end
        `IPC_ADDR_MISC: begin
          bus_voltage_compensation_enable_d = wr_word[`IPC_MISC_AVR_LSB];
          brake_chopper_mode_d = (wr_word[`IPC_MISC_BRAKE_LSB +: 2] == 2'h3) ? 2'h0 :
                                 wr_word[`IPC_MISC_BRAKE_LSB +: 2];
          phase_swap_select_d = wr_word[`IPC_MISC_SWAP_LSB];
          fan_control_mode_d = (wr_word[`IPC_MISC_FAN_LSB +: 2] == 2'h3) ? 2'h0 :
                               wr_word[`IPC_MISC_FAN_LSB +: 2];
          duty_type_select_d = wr_word[`IPC_MISC_DUTY_LSB];
        end
        `IPC_ADDR_THERM: begin
          fan_temp_d = wr_word[`IPC_TH_FAN_LSB +: 8];
          derate_temp_d = wr_word[`IPC_TH_DERATE_LSB +: 8];
        end
        `IPC_ADDR_BUSNOM: bus_nominal_d = wr_word[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      carrier_freq_setting_q <= CARRIER_DEFAULT;
      low_speed_carrier_q <= CARRIER_DEFAULT;
      high_speed_carrier_q <= CARRIER_DEFAULT;
      carrier_adjust_select_q <= `IPC_RST_ADJUST;
      carrier_switch_point_one_q <= `IPC_RST_PT_ONE;
      carrier_switch_point_two_q <= `IPC_RST_PT_TWO;
      modulation_scheme_select_q <= IPC_SCHEME_SV;
      discontinuous_switch_point_q <= `IPC_RST_DISC;
      modulation_limit_q <= `IPC_RST_LIMIT;
      bus_voltage_compensation_enable_q <= `IPC_RST_AVR;
      brake_chopper_mode_q <= `IPC_RST_BRAKE;
      phase_swap_select_q <= `IPC_RST_SWAP;
      fan_control_mode_q <= `IPC_RST_FAN;
      duty_type_select_q <= `IPC_RST_DUTY;
      fan_temp_q <= `IPC_RST_FAN_TEMP;
      derate_temp_q <= `IPC_RST_DERATE_TEMP;
      bus_nominal_q <= `IPC_RST_BUSNOM;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      carrier_freq_setting_q <= carrier_freq_setting_d;
      low_speed_carrier_q <= low_speed_carrier_d;
      high_speed_carrier_q <= high_speed_carrier_d;
      carrier_adjust_select_q <= carrier_adjust_select_d;
      carrier_switch_point_one_q <= carrier_switch_point_one_d;
      carrier_switch_point_two_q <= carrier_switch_point_two_d;
      modulation_scheme_select_q <= modulation_scheme_select_d;
      discontinuous_switch_point_q <= discontinuous_switch_point_d;
      modulation_limit_q <= modulation_limit_d;
      bus_voltage_compensation_enable_q <= bus_voltage_compensation_enable_d;
      brake_chopper_mode_q <= brake_chopper_mode_d;
      phase_swap_select_q <= phase_swap_select_d;
      fan_control_mode_q <= fan_control_mode_d;
      duty_type_select_q <= duty_type_select_d;
      fan_temp_q <= fan_temp_d;
      derate_temp_q <= derate_temp_d;
      bus_nominal_q <= bus_nominal_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulation datapath
  always_comb begin
    gain_raw = ipc_div({4'h0, bus_nominal_q, 12'h000}, {16'h0000, dc_bus_volt});
    gain = `IPC_GAIN_ONE;
    if (bus_voltage_compensation_enable_q) begin
      // Gain capped just below two (8191/4096) so a collapsing bus cannot overflow the path
      gain = (gain_raw > {18'h00000, `IPC_GAIN_MAX}) ? `IPC_GAIN_MAX : gain_raw[13:0];
    end
    s_u = 21'(scale(ref_u, gain));
    s_v = 21'(scale(ref_v, gain));
    s_w = 21'(scale(ref_w, gain));
    // Below 100% the clip level stays inside the linear range
    lim_raw = ipc_div({25'h0000000, modulation_limit_q} * 32'(`IPC_Q15_FULL), 32'h00000064);
    lim = $signed({1'b0, lim_raw[19:0]});
    mx = (s_u > s_v) ? ((s_u > s_w) ? s_u : s_w) : ((s_v > s_w) ? s_v : s_w);
    mn = (s_u < s_v) ? ((s_u < s_w) ? s_u : s_w) : ((s_v < s_w) ? s_v : s_w);
    sum = mx + mn;
    dpwm_now = modulation_scheme_select_q == IPC_SCHEME_SV_DPWM &&
               {1'b0, mod_pct} >= {2'h0, discontinuous_switch_point_q};
    cm = -(sum >>> 1);
    if (dpwm_now) begin
      // Clamp the phase of largest magnitude to its rail, so one leg stops switching
      cm = (sum >= 0) ? lim - mx : -lim - mn;
    end
    p_u = clip(s_u + cm, lim);
    p_v = clip(s_v + cm, lim);
    p_w = clip(s_w + cm, lim);
    overmod_d = modulation_limit_q >= `IPC_LIMIT_FULL &&
                (p_u > 21'sd32767 || p_u < -21'sd32767 || p_v > 21'sd32767 ||
                 p_v < -21'sd32767 || p_w > 21'sd32767 || p_w < -21'sd32767);
    dpwm_d = dpwm_now;
    thr_u_d = thr_u_q;
    thr_v_d = thr_v_q;
    thr_w_d = thr_w_q;
    if (car.period_end) begin
      thr_u_d = thresh(p_u, car.half_next);
      thr_v_d = phase_swap_select_q ? thresh(p_w, car.half_next) :
                thresh(p_v, car.half_next);
      thr_w_d = phase_swap_select_q ? thresh(p_v, car.half_next) :
                thresh(p_w, car.half_next);
    end
    pwm_u_d = drive_running && thr_u_q > car.cnt;
    pwm_v_d = drive_running && thr_v_q > car.cnt;
    pwm_w_d = drive_running && thr_w_q > car.cnt;
    unique case (brake_chopper_mode_q)
      2'h1: brake_d = 1'b1;
      2'h2: brake_d = ramp_stop;
      default: brake_d = 1'b0;
    endcase
    unique case (fan_control_mode_q)
      2'h1: fan_d = 1'b1;
      2'h2: fan_d = drive_temp > fan_temp_q;
      default: fan_d = drive_running;
    endcase
    light_d = duty_type_select_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      thr_u_q <= 18'h00000;
      thr_v_q <= 18'h00000;
      thr_w_q <= 18'h00000;
      pwm_u_q <= 1'b0;
      pwm_v_q <= 1'b0;
      pwm_w_q <= 1'b0;
      brake_q <= 1'b0;
      fan_q <= 1'b0;
      light_q <= 1'b0;
      dpwm_q <= 1'b0;
      overmod_q <= 1'b0;
    end else begin
      thr_u_q <= thr_u_d;
      thr_v_q <= thr_v_d;
      thr_w_q <= thr_w_d;
      pwm_u_q <= pwm_u_d;
      pwm_v_q <= pwm_v_d;
      pwm_w_q <= pwm_w_d;
      brake_q <= brake_d;
      fan_q <= fan_d;
      light_q <= light_d;
      dpwm_q <= dpwm_d;
      overmod_q <= overmod_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pwm_u = pwm_u_q;
  assign pwm_v = pwm_v_q;
  assign pwm_w = pwm_w_q;
  assign brake_chopper_en = brake_q;
  assign fan_on = fan_q;
  assign light_duty = light_q;
endmodule

//--- verification/ipc_bridge.sv
`timescale 1ns/1ps
module ipc_bridge (
  input wire logic sys_clk,
  input wire logic pwm_u,
  input wire logic pwm_v,
  input wire logic pwm_w,
  output logic [15:0] sw_cnt = 16'h0000
);
  logic [2:0] last_q = 3'h0;
  // Counts cycles with any gate edge; a stopped drive must show none
  always @(posedge sys_clk) begin
    if ({pwm_u, pwm_v, pwm_w} != last_q) sw_cnt <= sw_cnt + 16'h0001;
    last_q <= {pwm_u, pwm_v, pwm_w};
  end
endmodule

//--- verification/ipc_top_checker.sv
`timescale 1ns/1ps
module ipc_top_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] drive_temp,
  input wire logic drive_running,
  input wire logic ramp_stop,
  input wire logic pwm_u,
  input wire logic pwm_v,
  input wire logic pwm_w,
  input wire logic brake_chopper_en,
  input wire logic fan_on,
  input wire logic light_duty
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic wr;
  assign wr = psel && penable && pwrite && paddr == 8'h0C;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cfg_wr;
    $past(wr) || $past(wr, 2) || $past(rst) || $past(rst, 2);
  endsequence
  property p_rdy; s_setup |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; s_setup ##0 paddr > 8'h18 |=> pready && pslverr && prdata == 32'h0; endproperty
  property p_ok; s_setup ##0 (paddr <= 8'h18 && paddr[1:0] == 2'h0) |=> !pslverr; endproperty
  property p_off; !drive_running |=> !(pwm_u || pwm_v || pwm_w); endproperty
  property p_light; $changed(light_duty) |-> s_cfg_wr; endproperty
  property p_brake;
    $changed(brake_chopper_en) |-> s_cfg_wr or ($past(ramp_stop) != $past(ramp_stop, 2));
  endproperty
  property p_fan;
    $changed(fan_on) |-> s_cfg_wr or ($past(drive_running) != $past(drive_running, 2)) or
      ($past(drive_temp) != $past(drive_temp, 2));
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing after setup");
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_ok: assert property (p_ok) else $error("mapped access refused");
  a_off: assert property (p_off) else $error("gate on while stopped");
  a_light: assert property (p_light) else $error("duty type moved alone");
  a_brake: assert property (p_brake) else $error("brake moved alone");
  a_fan: assert property (p_fan) else $error("fan moved alone");
endmodule
bind ipc_top ipc_top_checker u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .drive_temp, .drive_running, .ramp_stop, .pwm_u, .pwm_v, .pwm_w,
  .brake_chopper_en, .fan_on, .light_duty);

//--- verification/tb_inverter_pwm_carrier_config.sv
`timescale 1ns/1ps
module tb_inverter_pwm_carrier_config;
  typedef struct {string nm; logic [32:0] exp;} ipc_note_s;
  ipc_note_s q[$];
  ipc_note_s note;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, probe = 1'b0;
  logic drive_running = 1'b0, ramp_stop = 1'b0;
  logic [7:0] paddr = 8'h00, drive_temp = 8'h00;
  logic [15:0] rnd = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pwm_u, pwm_v, pwm_w, brake_chopper_en, fan_on, light_duty;
  logic [15:0] sw_cnt;
  logic [31:0] rv [6] = '{32'h00282828, 32'h138802BC, 32'h00691E00, 32'h00000011,
    32'h0000503C, 32'h0000021C};
  int error_cnt = 0, checked = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  ipc_top uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
    .pready, .pslverr, .out_freq(rnd), .ref_u(rnd), .ref_v(~rnd), .ref_w(rnd ^ 16'h5A5A),
    .mod_pct(rnd[7:0]), .dc_bus_volt(16'h0200 + rnd[7:0]), .drive_temp, .drive_running,
    .ramp_stop, .pwm_u, .pwm_v, .pwm_w, .brake_chopper_en, .fan_on, .light_duty);
  ipc_bridge bridge (.sys_clk, .pwm_u, .pwm_v, .pwm_w, .sw_cnt);
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rnd <= 16'($urandom);
    if (cyc == 70000) begin
      error_cnt++;
      final_report();
    end
    // Oldest note pairs with the read or probe seen now
    if (((psel && penable && pready && !pwrite) || probe) && q.size() > 0) begin
      note = q.pop_front();
      chk(note.nm, note.exp,
          probe ? {30'h0, brake_chopper_en, fan_on, light_duty} : {pslverr, prdata});
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input string nm);
    q.push_back('{nm, e});
    apb(1'b0, a, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] bb, ff;
    void'($urandom(32'h4609));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rv[i]) begin
      rd(8'(4 * i), {1'b0, rv[i]}, "reset value");
    end
    rd(8'h1C, {1'b1, 32'h0}, "unmapped");
    apb(1'b1, 8'h00, 32'h03C8050A);
    rd(8'h00, {1'b0, 32'h03960A0A}, "carrier clamp");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 8'h08, {8'h0, 8'h78, 8'h05, 6'h0, 2'(s)});
      rd(8'h08, {1'b0, 8'h0, 8'h6E, 8'h0A, 6'h0, (s == 3) ? 2'h0 : 2'(s)},
         "modulation");
    end
    $display("test registers done");
    for (int m = 0; m < 16; m++) begin
      bb = (m[1:0] == 2'h3) ? 2'h0 : m[1:0];
      ff = (m[3:2] == 2'h3) ? 2'h0 : m[3:2];
      drive_running <= 1'($urandom);
      ramp_stop <= 1'($urandom);
      drive_temp <= 8'($urandom);
      apb(1'b1, 8'h0C, 32'({m[0], 2'h0, m[3:2], 3'h0, m[1], 2'h0, m[1:0], 4'h1}));
      rd(8'h0C, {1'b0, 32'({m[0], 2'h0, ff, 3'h0, m[1], 2'h0, bb, 4'h1})},
         "misc");
      repeat (3) @(posedge sys_clk);
      q.push_back('{"pins", {30'h0, bb == 2'h1 || (bb == 2'h2 && ramp_stop),
        ff == 2'h1 || (ff == 2'h0 && drive_running) ||
        (ff == 2'h2 && drive_temp > 8'h3C),
        m[0]}});
      probe <= 1'b1;
      @(posedge sys_clk);
      probe <= 1'b0;
    end
    $display("test modes done");
    chk("gate edges", 33'h0, {17'h0, sw_cnt});
    // First valley lands about 62500 cycles after reset
    drive_running <= 1'b1;
    repeat (63000) @(posedge sys_clk);
    chk("gate edges running", 33'h1, {32'h0, sw_cnt != 16'h0000});
    $display("test run done");
    final_report();
  end
endmodule
